// File: single_wire_slave.sv
// bit-level signalling front end of a single-wire bus slave
`timescale 1ns/1ns
module single_wire_slave
    import single_wire_pkg::*;
#(
    parameter int RST_LOW_STD_US = 480,
    parameter int OD_EXIT_US     = 690
)(
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic clkEn,
    input  wire logic lineIn,
    output logic      lineOut,
    output logic      lineOeN,
    input  wire logic txValid,
    input  wire logic txBit,
    output logic      txReady,
    output logic      rxValid,
    output logic      rxBit,
    input  wire logic rxReady,
    output logic      rxDrop,
    input  wire logic setOverdrive,
    output logic      overdrive,
    output logic      resetPulse
);
    localparam logic [CNT_W-1:0] RST_LOW_STD_CYC = CNT_W'(cycMin(RST_LOW_STD_US * 1000));
    localparam logic [CNT_W-1:0] OD_EXIT_CYC     = CNT_W'(cycMin(OD_EXIT_US * 1000));

    typedef struct packed {
        link_state_t      st;
        logic [CNT_W-1:0] cnt;
        logic             lineQ;
        logic             od;
        logic             isRead;
        logic             rdBit;
        logic             sampled;
        logic             drvN;
        logic             outLvl;
        logic             txReady;
        logic             resetPulse;
        logic             pushV;
        logic             pushBit;
        logic             drop;
    } slave_state_t;

    localparam slave_state_t RESET_STATE = '{
        st: S_IDLE, cnt: CNT_ZERO, lineQ: 1'b1, od: 1'b0, isRead: 1'b0,
        rdBit: 1'b1, sampled: 1'b0, drvN: 1'b1, outLvl: 1'b0, txReady: 1'b0,
        resetPulse: 1'b0, pushV: 1'b0, pushBit: 1'b0, drop: 1'b0
    };

    // pick the threshold of the active speed
    function automatic logic [CNT_W-1:0] pickCyc(
        input logic             fast,
        input logic [CNT_W-1:0] stdCyc,
        input logic [CNT_W-1:0] odCyc
    );
        return fast ? odCyc : stdCyc;
    endfunction : pickCyc

    slave_state_t     s_reg;
    slave_state_t     s_next;
    logic             fifoInReady;
    logic [CNT_W-1:0] cntInc;
    logic [CNT_W-1:0] pdhSel;
    logic [CNT_W-1:0] pdlSel;
    logic [CNT_W-1:0] sampleSel;
    logic [CNT_W-1:0] rdHoldSel;
    logic [CNT_W-1:0] holdoffSel;
    logic [CNT_W-1:0] rstSel;
    logic             riseNow;

    assign cntInc     = (s_reg.cnt == CNT_MAX) ? CNT_MAX : CNT_W'(s_reg.cnt + CNT_ONE);
    assign pdhSel     = pickCyc(s_reg.od, PRES_HIGH_STD_CYC, PRES_HIGH_OD_CYC);
    assign pdlSel     = pickCyc(s_reg.od, PRES_LOW_STD_CYC, PRES_LOW_OD_CYC);
    assign sampleSel  = pickCyc(s_reg.od, WR_SAMPLE_STD_CYC, WR_SAMPLE_OD_CYC);
    assign rdHoldSel  = pickCyc(s_reg.od, RD_HOLD_STD_CYC, RD_HOLD_OD_CYC);
    assign holdoffSel = pickCyc(s_reg.od, HOLDOFF_STD_CYC, HOLDOFF_OD_CYC);
    assign rstSel     = pickCyc(s_reg.od, RST_LOW_STD_CYC, RST_LOW_OD_CYC);
    // line back high while this end is not pulling it
    assign riseNow    = (s_reg.st == S_LOW) && s_reg.lineQ && s_reg.drvN;

    always_comb
    begin
        s_next            = s_reg;
        s_next.lineQ      = lineIn;
        s_next.txReady    = 1'b0;
        s_next.resetPulse = 1'b0;
        s_next.pushV      = 1'b0;
        s_next.drop       = s_reg.pushV && !fifoInReady;
        case (s_reg.st)
            S_IDLE:
            begin
                if (!s_reg.lineQ)
                begin
                    s_next.cnt = CNT_ONE;
                    s_next.st  = S_FILTER;
                    if (s_reg.od)
                    begin
                        s_next.st      = S_LOW;
                        s_next.cnt     = CNT_W'(CNT_ONE + CNT_ONE);
                        s_next.sampled = 1'b0;
                        s_next.isRead  = txValid;
                        s_next.rdBit   = txBit;
                        s_next.txReady = txValid;
                        s_next.drvN    = !(txValid && !txBit);
                    end
                end
            end
            S_FILTER:
            begin
                if (s_reg.lineQ)
                begin
                    s_next.st = S_IDLE;
                end
                else if (s_reg.cnt >= FALL_FILTER_CYC)
                begin
                    s_next.st      = S_LOW;
                    s_next.cnt     = cntInc;
                    s_next.sampled = 1'b0;
                    s_next.isRead  = txValid;
                    s_next.rdBit   = txBit;
                    s_next.txReady = txValid;
                    s_next.drvN    = !(txValid && !txBit);
                end
                else
                begin
                    s_next.cnt = cntInc;
                end
            end
            S_LOW:
            begin
                s_next.cnt = cntInc;
                if (!s_reg.drvN && s_reg.cnt >= rdHoldSel)
                begin
                    s_next.drvN = 1'b1;
                end
                if (riseNow)
                begin
                    s_next.cnt = CNT_ZERO;
                    if (s_reg.cnt >= rstSel)
                    begin
                        s_next.st         = S_PDH;
                        s_next.resetPulse = 1'b1;
                        if (s_reg.cnt >= OD_EXIT_CYC)
                        begin
                            s_next.od = 1'b0;
                        end
                        // shorter overdrive resets leave the flag alone
                    end
                    else
                    begin
                        s_next.st = S_HOLDOFF;
                        if (!s_reg.isRead)
                        begin
                            s_next.pushV   = 1'b1;
                            s_next.pushBit = s_reg.sampled ? s_reg.pushBit : 1'b1;
                        end
                    end
                end
                else if (!s_reg.isRead && !s_reg.sampled && s_reg.cnt == sampleSel)
                begin
                    // bit held until the rising edge proves this was a slot, not a reset
                    s_next.sampled = 1'b1;
                    s_next.pushBit = s_reg.lineQ;
                end
            end
            S_HOLDOFF:
            begin
                s_next.cnt = cntInc;
                if (cntInc >= holdoffSel)
                begin
                    s_next.st = S_IDLE;
                end
            end
            S_PDH:
            begin
                s_next.cnt = cntInc;
                if (cntInc >= pdhSel)
                begin
                    s_next.st   = S_PDL;
                    s_next.cnt  = CNT_ZERO;
                    s_next.drvN = 1'b0;
                end
            end
            S_PDL:
            begin
                s_next.cnt = cntInc;
                if (cntInc >= pdlSel)
                begin
                    s_next.st   = S_PRELEASE;
                    s_next.drvN = 1'b1;
                end
            end
            S_PRELEASE:
            begin
                if (s_reg.lineQ)
                begin
                    s_next.st  = S_HOLDOFF;
                    s_next.cnt = CNT_ZERO;
                end
            end
            default:
            begin
                s_next = RESET_STATE;
            end
        endcase
        if (setOverdrive)
        begin
            s_next.od = 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s_reg <= RESET_STATE;
        end
        else if (clkEn)
        begin
            s_reg <= s_next;
        end
    end

    bit_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .clkEn    (clkEn),
        .inValid  (s_reg.pushV),
        .inData   (s_reg.pushBit),
        .inReady  (fifoInReady),
        .outValid (rxValid),
        .outData  (rxBit),
        .outReady (rxReady)
    );

    assign lineOut    = s_reg.outLvl;
    assign lineOeN    = s_reg.drvN;
    assign txReady    = s_reg.txReady;
    assign overdrive  = s_reg.od;
    assign resetPulse = s_reg.resetPulse;
    assign rxDrop     = s_reg.drop;

    // helper: cycles the line has been pulled by this end
    logic [CNT_W-1:0] drvLen;
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            drvLen <= CNT_ZERO;
        end
        else if (clkEn)
        begin
            drvLen <= s_reg.drvN ? CNT_ZERO : CNT_W'(drvLen + CNT_ONE);
        end
    end

    default clocking cb @(posedge ref_clk iff clkEn);
    endclocking
    default disable iff (rst);

    sequence presStart;
        s_reg.st == S_PDH && s_reg.cnt == CNT_ZERO;
    endsequence

    sequence resetRise;
        riseNow && s_reg.cnt >= rstSel;
    endsequence

    sequence readZeroStart;
        s_reg.txReady && !s_reg.rdBit;
    endsequence

    a_od_bypass: assert property (
        (s_reg.st == S_IDLE && s_reg.od && !s_reg.lineQ) |=> s_reg.st == S_LOW)
        else $error("overdrive falling edge was filtered");

    a_std_filter: assert property (
        (s_reg.st == S_IDLE && !s_reg.od && !s_reg.lineQ) |=> s_reg.st == S_FILTER)
        else $error("standard falling edge skipped filter");

    a_exit_od: assert property (
        (resetRise and (s_reg.cnt >= OD_EXIT_CYC && !setOverdrive)) |=> !s_reg.od)
        else $error("long reset kept overdrive");

    a_keep_od: assert property (
        (resetRise and (s_reg.od && s_reg.cnt <= OD_KEEP_MAX_CYC))
        |=> s_reg.od && s_reg.st == S_PDH && s_reg.resetPulse)
        else $error("short overdrive reset lost overdrive");

    a_pres_quiet: assert property (
        presStart |-> s_reg.drvN [*8])
        else $error("presence driven before delay");

    a_pres_len: assert property (
        (s_reg.st == S_PRELEASE && $past(s_reg.st) == S_PDL) |-> drvLen == $past(pdlSel))
        else $error("presence low duration wrong");

    a_write_push: assert property (
        (s_reg.st == S_LOW && !riseNow && !s_reg.isRead && !s_reg.sampled
         && s_reg.cnt == sampleSel) |=> s_reg.sampled && !s_reg.pushBit && !s_reg.pushV)
        else $error("write slot not sampled at timer instant");

    a_zero_push: assert property (
        (riseNow && s_reg.cnt < rstSel && !s_reg.isRead && s_reg.sampled)
        |=> s_reg.pushV && !s_reg.pushBit)
        else $error("write zero slot not delivered");

    a_one_push: assert property (
        (riseNow && s_reg.cnt < rstSel && !s_reg.isRead && !s_reg.sampled)
        |=> s_reg.pushV && s_reg.pushBit)
        else $error("write one slot not delivered");

    a_reset_nopush: assert property (
        resetRise |=> !s_reg.pushV)
        else $error("reset delivered a data bit");

    a_read_zero: assert property (
        readZeroStart |-> !s_reg.drvN [*8])
        else $error("read zero not driven low");

    a_read_one: assert property (
        (s_reg.txReady && s_reg.rdBit) |-> s_reg.drvN [*8])
        else $error("read one pulled the line");

    a_holdoff_skip: assert property (
        (s_reg.st == S_HOLDOFF && cntInc < holdoffSel) |=> s_reg.st == S_HOLDOFF)
        else $error("glitch inside hold-off started a slot");

    a_set_od: assert property (
        setOverdrive |=> s_reg.od)
        else $error("overdrive command not taken");

endmodule : single_wire_slave

// File: single_wire_pkg.sv
// constants, timing and state types for the single-wire slave front end
package single_wire_pkg;

    localparam int CLK_PERIOD_NS = 100;
    localparam int CNT_W         = 14;
    localparam int FIFO_WIDTH    = 1;
    localparam int FIFO_DEPTH    = 32;

    // least time rounds up, longest time rounds down, never below one cycle
    function automatic int cycMin(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : cycMin

    function automatic int cycMax(input int ns);
        int c;
        c = ns / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : cycMax

    // times in ns
    localparam int PRES_HIGH_STD_NS  = 30000;
    localparam int PRES_HIGH_OD_NS   = 3000;
    localparam int PRES_LOW_STD_NS   = 120000;
    localparam int PRES_LOW_OD_NS    = 10000;
    localparam int WR_SAMPLE_STD_NS  = 30000;
    localparam int WR_SAMPLE_OD_NS   = 3000;
    localparam int RD_HOLD_STD_NS    = 30000;
    localparam int RD_HOLD_OD_NS     = 3000;
    localparam int HOLDOFF_STD_NS    = 1000;
    localparam int HOLDOFF_OD_NS     = 500;
    localparam int RST_LOW_OD_NS     = 48000;
    localparam int OD_KEEP_MAX_NS    = 80000;
    localparam int FALL_FILTER_NS    = 300;

    localparam logic [CNT_W-1:0] PRES_HIGH_STD_CYC = CNT_W'(cycMin(PRES_HIGH_STD_NS));
    localparam logic [CNT_W-1:0] PRES_HIGH_OD_CYC  = CNT_W'(cycMin(PRES_HIGH_OD_NS));
    localparam logic [CNT_W-1:0] PRES_LOW_STD_CYC  = CNT_W'(cycMin(PRES_LOW_STD_NS));
    localparam logic [CNT_W-1:0] PRES_LOW_OD_CYC   = CNT_W'(cycMin(PRES_LOW_OD_NS));
    localparam logic [CNT_W-1:0] WR_SAMPLE_STD_CYC = CNT_W'(cycMax(WR_SAMPLE_STD_NS));
    localparam logic [CNT_W-1:0] WR_SAMPLE_OD_CYC  = CNT_W'(cycMax(WR_SAMPLE_OD_NS));
    localparam logic [CNT_W-1:0] RD_HOLD_STD_CYC   = CNT_W'(cycMin(RD_HOLD_STD_NS));
    localparam logic [CNT_W-1:0] RD_HOLD_OD_CYC    = CNT_W'(cycMin(RD_HOLD_OD_NS));
    localparam logic [CNT_W-1:0] HOLDOFF_STD_CYC   = CNT_W'(cycMin(HOLDOFF_STD_NS));
    localparam logic [CNT_W-1:0] HOLDOFF_OD_CYC    = CNT_W'(cycMin(HOLDOFF_OD_NS));
    localparam logic [CNT_W-1:0] RST_LOW_OD_CYC    = CNT_W'(cycMin(RST_LOW_OD_NS));
    localparam logic [CNT_W-1:0] OD_KEEP_MAX_CYC   = CNT_W'(cycMax(OD_KEEP_MAX_NS));
    localparam logic [CNT_W-1:0] FALL_FILTER_CYC   = CNT_W'(cycMin(FALL_FILTER_NS));
    localparam logic [CNT_W-1:0] CNT_ONE           = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_ZERO          = CNT_W'(0);
    localparam logic [CNT_W-1:0] CNT_MAX           = {CNT_W{1'b1}};

    typedef enum logic [2:0] {
        S_IDLE,
        S_FILTER,
        S_LOW,
        S_HOLDOFF,
        S_PDH,
        S_PDL,
        S_PRELEASE
    } link_state_t;

endpackage : single_wire_pkg

// File: bit_fifo.sv
// small synchronous fifo with registered output stage
`timescale 1ns/1ns
module bit_fifo
    import single_wire_pkg::*;
#(
    parameter int WIDTH = FIFO_WIDTH,
    parameter int DEPTH = FIFO_DEPTH
)(
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             clkEn,
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    output logic                  outValid,
    output logic      [WIDTH-1:0] outData,
    input  wire logic             outReady
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_FW = $clog2(DEPTH + 1);
    localparam logic [CNT_FW-1:0] FULL_CNT = CNT_FW'(DEPTH);

    typedef struct packed {
        logic [PTR_W-1:0]  wrPtr;
        logic [PTR_W-1:0]  rdPtr;
        logic [CNT_FW-1:0] count;
        logic              outValid;
        logic [WIDTH-1:0]  outData;
    } fifo_state_t;

    fifo_state_t      s_reg;
    fifo_state_t      s_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             load;

    // the output stage counts as one of the words, so the whole fifo holds DEPTH
    assign inReady  = (CNT_FW'(s_reg.count + CNT_FW'(s_reg.outValid)) != FULL_CNT);
    assign push     = inValid && inReady;
    assign load     = (s_reg.count != '0) && (!s_reg.outValid || outReady);
    assign outValid = s_reg.outValid;
    assign outData  = s_reg.outData;

    always_comb
    begin
        s_next = s_reg;
        if (push)
        begin
            s_next.wrPtr = PTR_W'(s_reg.wrPtr + 1'b1);
        end
        if (load)
        begin
            s_next.rdPtr    = PTR_W'(s_reg.rdPtr + 1'b1);
            s_next.outData  = mem[s_reg.rdPtr];
            s_next.outValid = 1'b1;
        end
        else if (outReady)
        begin
            s_next.outValid = 1'b0;
        end
        s_next.count = CNT_FW'(s_reg.count + CNT_FW'(push) - CNT_FW'(load));
    end

    always_ff @(posedge ref_clk)
    begin
        if (clkEn && push)
        begin
            mem[s_reg.wrPtr] <= inData;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s_reg <= '0;
        end
        else if (clkEn)
        begin
            s_reg <= s_next;
        end
    end

endmodule : bit_fifo

// File: single_wire_master_model.sv
// bus master model: drives the shared line, pull-up when nobody pulls low
`timescale 1ns/1ns
module single_wire_master_model (
    input  wire logic ref_clk,
    input  wire logic lineOeN,
    output logic      lineIn
);
    logic drvLow = 1'b0;

    // wired-and of both pulldowns
    assign lineIn = !(drvLow || (lineOeN === 1'b0));

    // one slot: low phase, optional glitch after release, master sample at a fixed cycle of the slot, rest of slot
    task automatic slot(input bit od, input int lowCyc, input int glCyc, output logic smp);
        int slotLen;
        int smpAt;
        slotLen = od ? 80 : 700;
        smpAt   = od ? 12 : 150;
        smp     = 1'bx;
        for (int i = 0; i < slotLen; i++)
        begin
            drvLow = (i < lowCyc) || (glCyc > 0 && i > lowCyc && i <= lowCyc + glCyc);
            if (i == smpAt)
                smp = lineIn;
            @(negedge ref_clk);
        end
    endtask : slot

    // reset low, then watch presence over a stretched reset-high period
    task automatic resetSeq(input bit od, input int lowCyc, output int dly, output int len,
                            output logic pres);
        int winLen;
        winLen = od ? 480 : 4800;
        dly    = -1;
        len    = 0;
        pres   = 1'bx;
        drvLow = 1'b1;
        repeat (lowCyc) @(negedge ref_clk);
        drvLow = 1'b0;
        for (int i = 0; i < winLen; i++)
        begin
            @(negedge ref_clk);
            if (lineOeN === 1'b0)
            begin
                if (dly < 0)
                    dly = i;
                len++;
            end
            if (i == (od ? 80 : 600))
                pres = ~lineIn;
        end
    endtask : resetSeq
endmodule : single_wire_master_model

// File: single_wire_slave_tb.sv
// self-checking bench for the single-wire slave front end
`timescale 1ns/1ns
module single_wire_slave_tb;
    import single_wire_pkg::*;

    logic ref_clk      = 1'b0;
    logic rst          = 1'b1;
    logic clkEn        = 1'b1;
    logic txValid      = 1'b0;
    logic txBit        = 1'b0;
    logic rxReady      = 1'b0;
    logic setOverdrive = 1'b0;
    wire logic lineIn;
    logic lineOut, lineOeN, txReady, rxValid, rxBit, rxDrop, overdrive, resetPulse;
    int   errorCnt = 0;
    int   compares = 0;
    int   cycles   = 0;
    int   dropCnt  = 0;
    int   resetCnt = 0;
    logic expQ[$];
    logic gotQ[$];
    logic smp;

    always #50 ref_clk = ~ref_clk;

    single_wire_slave dut (
        .ref_clk(ref_clk), .clkEn(clkEn), .rst(rst), .lineIn(lineIn), .lineOut(lineOut),
        .lineOeN(lineOeN), .txValid(txValid), .txBit(txBit), .txReady(txReady),
        .rxValid(rxValid), .rxBit(rxBit), .rxReady(rxReady), .rxDrop(rxDrop),
        .setOverdrive(setOverdrive), .overdrive(overdrive), .resetPulse(resetPulse)
    );

    single_wire_master_model m (.ref_clk(ref_clk), .lineOeN(lineOeN), .lineIn(lineIn));

    always @(posedge ref_clk)
    begin
        cycles++;
        if (rxDrop === 1'b1)
            dropCnt++;
        if (resetPulse === 1'b1)
            resetCnt++;
        if (cycles == 40000)
        begin
            errorCnt++;
            $display("BAD %0t run did not finish in time", $time);
            test_done();
        end
    end

    // the upper layer drops its bit once the slot has taken it
    always @(negedge ref_clk)
        if (txReady === 1'b1)
            txValid = 1'b0;

    task automatic checkBit(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask : checkBit

    task automatic checkNum(input int got, input int lo, input int hi, input string what);
        compares++;
        if (got < lo || got > hi)
        begin
            errorCnt++;
            $display("BAD %0t %s got %0d exp %0d..%0d", $time, what, got, lo, hi);
        end
    endtask : checkNum

    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, errorCnt);
        if (errorCnt == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    task automatic drain();
        gotQ = {};
        for (int i = 0; i < 80; i++)
        begin
            if (rxValid === 1'b1)
                gotQ.push_back(rxBit);
            rxReady = 1'b1;
            @(negedge ref_clk);
        end
        rxReady = 1'b0;
        checkNum(gotQ.size(), expQ.size(), expQ.size(), "fifo count");
        foreach (gotQ[i])
            if (i < expQ.size())
                checkBit(gotQ[i], expQ[i], "fifo bit");
        expQ = {};
    endtask : drain

    task automatic wr(input bit od, input bit b);
        m.slot(od, b ? (od ? 3 : 6) : (od ? 50 : 400), 0, smp);
        expQ.push_back(b);
    endtask : wr

    task automatic rd(input bit od, input bit b);
        txValid = 1'b1;
        txBit   = b;
        m.slot(od, od ? 3 : 6, 0, smp);
        checkBit(smp, b, "read bit");
        checkBit(lineOut, 1'b0, "pulled level");
        checkBit(txValid, 1'b0, "tx bit taken");
    endtask : rd

    task automatic doReset(input bit od, input int lowCyc, input logic expOd);
        int dly;
        int len;
        int hi;
        int r0;
        logic pres;
        r0 = resetCnt;
        hi = od ? int'(PRES_HIGH_OD_CYC) : int'(PRES_HIGH_STD_CYC);
        m.resetSeq(od, lowCyc, dly, len, pres);
        checkNum(dly, hi, hi + 4, "presence delay");
        checkNum(len, od ? int'(PRES_LOW_OD_CYC) : int'(PRES_LOW_STD_CYC),
                 od ? int'(PRES_LOW_OD_CYC) : int'(PRES_LOW_STD_CYC), "presence low");
        checkBit(pres, 1'b1, "presence seen");
        checkBit(overdrive, expOd, "speed after reset");
        checkNum(resetCnt, r0 + 1, r0 + 1, "reset pulses");
    endtask : doReset

    task automatic test_std();
        doReset(1'b0, 4900, 1'b0);
        wr(1'b0, 1'b0);
        wr(1'b0, 1'b1);
        rd(1'b0, 1'b0);
        rd(1'b0, 1'b1);
        wr(1'b0, 1'b1);
        drain();
        $display("test standard slots done");
    endtask : test_std

    task automatic test_std_glitch();
        clkEn        = 1'b0;
        setOverdrive = 1'b1;
        repeat (3) @(negedge ref_clk);
        setOverdrive = 1'b0;
        clkEn        = 1'b1;
        @(negedge ref_clk);
        checkBit(overdrive, 1'b0, "frozen while disabled");
        txValid = 1'b1;
        txBit   = 1'b0;
        m.slot(1'b0, 2, 0, smp);
        checkBit(txValid, 1'b1, "short low not a slot");
        txValid = 1'b0;
        drain();
        $display("test standard filter done");
    endtask : test_std_glitch

    task automatic test_od();
        setOverdrive = 1'b1;
        @(negedge ref_clk);
        setOverdrive = 1'b0;
        @(negedge ref_clk);
        checkBit(overdrive, 1'b1, "overdrive set");
        doReset(1'b1, 500, 1'b1);
        wr(1'b1, 1'b0);
        wr(1'b1, 1'b1);
        rd(1'b1, 1'b0);
        rd(1'b1, 1'b1);
        m.slot(1'b1, 2, 0, smp);
        expQ.push_back(1'b1);
        m.slot(1'b1, 50, 2, smp);
        expQ.push_back(1'b0);
        drain();
        $display("test overdrive slots done");
    endtask : test_od

    task automatic test_fill();
        int d0;
        int drops;
        d0 = dropCnt;
        for (int i = 0; i < 34; i++)
            wr(1'b1, (i % 3) == 0);
        drops = dropCnt - d0;
        checkNum(drops, 34 - FIFO_DEPTH, 34 - FIFO_DEPTH, "bits dropped when full");
        repeat (drops) void'(expQ.pop_back());
        drain();
        $display("test fifo fill done");
    endtask : test_fill

    task automatic test_exit();
        doReset(1'b0, 7000, 1'b0);
        wr(1'b0, 1'b0);
        drain();
        $display("test overdrive exit done");
    endtask : test_exit

    initial
    begin
        repeat (6) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
        test_std();
        test_std_glitch();
        test_od();
        test_fill();
        test_exit();
        test_done();
    end
endmodule : single_wire_slave_tb
